// *** common/blc_pkg.sv ***
package blc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] BLC_MODE_ADDR = 8'h00;
	localparam logic [7:0] BLC_CTRL_ADDR = 8'h02;
	localparam logic [7:0] BLC_TIME_ADDR = 8'h03;
	localparam logic [7:0] BLC_MODE_RESET = 8'h00;
	localparam logic [7:0] BLC_CTRL_RESET = 8'h00;
	localparam logic [7:0] BLC_TIME_RESET = 8'h00;
	// mode register fields
	localparam int BLC_STBY_BIT = 7;
	localparam int BLC_BLON_BIT = 6;
	localparam int BLC_DIM_BIT = 5;
	// backlight_control fields
	localparam int BLC_LVL_HI = 7;
	localparam int BLC_LVL_LO = 6;
	localparam int BLC_LAW_HI = 5;
	localparam int BLC_LAW_LO = 4;
	localparam int BLC_AUTO_BIT = 3;
	localparam int BLC_OVP_BIT = 2;
	localparam int BLC_OVRD_BIT = 1;
	localparam int BLC_KEY_BIT = 0;
	// backlight_off_dim_timers fields
	localparam int BLC_OFFT_HI = 7;
	localparam int BLC_OFFT_LO = 4;
	localparam int BLC_DIMT_HI = 3;
	localparam int BLC_DIMT_LO = 0;
	// ----------------------------------------
	// encodings
	// ----------------------------------------
	localparam logic [1:0] BLC_LVL_DAYLIGHT = 2'h0;
	localparam logic [1:0] BLC_LVL_OFFICE = 2'h1;
	localparam logic [1:0] BLC_LVL_DARK = 2'h2;
	localparam logic [1:0] BLC_LAW_LINEAR = 2'h0;
	localparam logic [1:0] BLC_LAW_SQUARE = 2'h1;
	localparam logic [1:0] BLC_LAW_CUBIC1 = 2'h2;
	localparam logic [1:0] BLC_LAW_CUBIC2 = 2'h3;
	localparam logic [3:0] BLC_CODE_OFF = 4'h0;
	localparam logic [7:0] BLC_FIRST_LONG = 8'h08;
	localparam logic [7:0] BLC_SHORT_BASE = 8'h05;
	localparam logic [7:0] BLC_SHORT_STEP = 8'h05;
	localparam logic [7:0] BLC_LONG_STEP = 8'h0A;
	localparam logic [7:0] BLC_LONG_OFFSET = 8'h1E;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int BLC_TIMER_UNIT_S = 1;
	localparam int BLC_CLK_HZ = 250_000_000;
	localparam int BLC_CYC_PER_SEC = BLC_TIMER_UNIT_S * BLC_CLK_HZ;

	// timer code to seconds, zero means disabled
	function automatic logic [6:0] blc_code_to_sec(input logic [3:0] code);
		logic [7:0] c;
		c = {4'h0, code};
		if (code == BLC_CODE_OFF) begin
			return 7'h00;
		end else if (c < BLC_FIRST_LONG) begin
			return 7'(BLC_SHORT_BASE + BLC_SHORT_STEP * c);
		end else begin
			return 7'(BLC_LONG_STEP * c - BLC_LONG_OFFSET);
		end
	endfunction : blc_code_to_sec
endpackage : blc_pkg

// *** hdl/blc_core.sv ***
`timescale 1ns/1ps
// What this block does
// - bits 7:6 of backlight_control pick daylight, office or dark level.
// - bits 5:4 pick the fade law: linear, square, cubic one or cubic two.
// - with auto level off, only the software level field sets the level.
// - with auto level on, the ambient comparators drive the level field.
// - bit 2 lets an overvoltage condition ramp the backlight down.
// - bit 1 turns the fade override on or off.
// - with bit 0 set, a key press sets backlight_on; otherwise it does nothing.
// - off timer code 0 disables, 1-7 give 10-40 s by 5, 8-15 give 50-120 s by 10.
// - the dim timer code in bits 3:0 uses the same encoding.
// - dim timer expiry sets the dim bit, which holds until cleared.
// - drive, dim, ramp-down, fade override and key wake work only while standby is released; level and law do not wait for it.
module blc_core
	import blc_pkg::*;
#(
	parameter int CYC_PER_SEC = BLC_CYC_PER_SEC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// events from neighbouring blocks
	input wire logic [1:0] ambient_level_i,
	input wire logic ovp_detect_i,
	input wire logic key_press_i,
	// backlight controls
	output logic [1:0] brightness_level_sel_o,
	output logic [1:0] fade_transfer_law_o,
	output logic backlight_drive_o,
	output logic dim_active_o,
	output logic ovp_rampdown_o,
	output logic fade_override_o
);
	localparam int TICK_W = $clog2(CYC_PER_SEC);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYC_PER_SEC - 1);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// one-second step of a timer that parks at zero
	function automatic logic [6:0] blc_step_down(input logic step, input logic [6:0] cnt);
		if (step && cnt != 7'h00) begin
			return 7'(cnt - 7'h01);
		end
		return cnt;
	endfunction : blc_step_down

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic standby_release;
	logic backlight_on;
	logic dim_enable;
	logic [1:0] brightness_level_sel;
	logic [1:0] fade_transfer_law;
	logic ambient_auto_level;
	logic overvoltage_rampdown_enable;
	logic fade_override_enable;
	logic keypress_wake_enable;
	logic [3:0] off_timer_code;
	logic [3:0] dim_timer_code;
	logic [6:0] off_cnt;
	logic [6:0] dim_cnt;
	logic [TICK_W-1:0] tick_cnt;
	logic run_d;
	logic [1:0] amb_s1;
	logic [1:0] amb_s2;
	logic ovp_s1;
	logic ovp_s2;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire wr_mode = reg_wr_i && (reg_addr_i == BLC_MODE_ADDR);
	wire wr_ctrl = reg_wr_i && (reg_addr_i == BLC_CTRL_ADDR);
	wire wr_time = reg_wr_i && (reg_addr_i == BLC_TIME_ADDR);
	wire run = standby_release && backlight_on;
	wire reload = run && !run_d;
	wire tick = run && (tick_cnt == TICK_LAST);
	wire off_exp = tick && (off_cnt == 7'h01);
	wire dim_exp = tick && (dim_cnt == 7'h01);
	wire key_wake = key_press_i && keypress_wake_enable && standby_release;
	// unused comparator code falls back to dark
	wire [1:0] amb_lvl = (amb_s2 == 2'h3) ? BLC_LVL_DARK : amb_s2;

	// ----------------------------------------
	// next values
	// ----------------------------------------
	// set beats clear: key wake wins over a write or off expiry
	wire next_backlight_on = key_wake ? 1'b1 :
		wr_mode ? reg_wdata_i[BLC_BLON_BIT] :
		off_exp ? 1'b0 : backlight_on;
	wire next_dim_enable = dim_exp ? 1'b1 :
		wr_mode ? reg_wdata_i[BLC_DIM_BIT] : dim_enable;
	wire [1:0] next_level = ambient_auto_level ? amb_lvl :
		wr_ctrl ? reg_wdata_i[BLC_LVL_HI:BLC_LVL_LO] : brightness_level_sel;
	wire [6:0] next_off_cnt = reload ? blc_code_to_sec(off_timer_code) :
		blc_step_down(tick, off_cnt);
	wire [6:0] next_dim_cnt = reload ? blc_code_to_sec(dim_timer_code) :
		blc_step_down(tick, dim_cnt);
	wire [TICK_W-1:0] next_tick_cnt = (!run || reload || tick) ? '0 :
		TICK_W'(tick_cnt + 1'b1);
	wire [7:0] mode_rd = {standby_release, backlight_on, dim_enable, 5'h00};
	wire [7:0] ctrl_rd = {brightness_level_sel, fade_transfer_law, ambient_auto_level,
		overvoltage_rampdown_enable, fade_override_enable, keypress_wake_enable};
	wire [7:0] time_rd = {off_timer_code, dim_timer_code};
	wire [7:0] next_rdata = (reg_addr_i == BLC_MODE_ADDR) ? mode_rd :
		(reg_addr_i == BLC_CTRL_ADDR) ? ctrl_rd :
		(reg_addr_i == BLC_TIME_ADDR) ? time_rd : 8'h00;

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			amb_s1 <= 2'h0;
			amb_s2 <= 2'h0;
			ovp_s1 <= 1'b0;
			ovp_s2 <= 1'b0;
		end else begin
			amb_s1 <= ambient_level_i;
			amb_s2 <= amb_s1;
			ovp_s1 <= ovp_detect_i;
			ovp_s2 <= ovp_s1;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			{standby_release, backlight_on, dim_enable} <= BLC_MODE_RESET[7:5];
			{brightness_level_sel, fade_transfer_law, ambient_auto_level,
				overvoltage_rampdown_enable, fade_override_enable,
				keypress_wake_enable} <= BLC_CTRL_RESET;
			{off_timer_code, dim_timer_code} <= BLC_TIME_RESET;
		end else begin
			if (wr_mode) begin
				standby_release <= reg_wdata_i[BLC_STBY_BIT];
			end
			if (wr_ctrl) begin
				fade_transfer_law <= reg_wdata_i[BLC_LAW_HI:BLC_LAW_LO];
				ambient_auto_level <= reg_wdata_i[BLC_AUTO_BIT];
				overvoltage_rampdown_enable <= reg_wdata_i[BLC_OVP_BIT];
				fade_override_enable <= reg_wdata_i[BLC_OVRD_BIT];
				keypress_wake_enable <= reg_wdata_i[BLC_KEY_BIT];
			end
			if (wr_time) begin
				off_timer_code <= reg_wdata_i[BLC_OFFT_HI:BLC_OFFT_LO];
				dim_timer_code <= reg_wdata_i[BLC_DIMT_HI:BLC_DIMT_LO];
			end
			backlight_on <= next_backlight_on;
			dim_enable <= next_dim_enable;
			brightness_level_sel <= next_level;
		end
	end

	// ----------------------------------------
	// timers
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			off_cnt <= 7'h00;
			dim_cnt <= 7'h00;
			tick_cnt <= '0;
			run_d <= 1'b0;
		end else begin
			off_cnt <= next_off_cnt;
			dim_cnt <= next_dim_cnt;
			tick_cnt <= next_tick_cnt;
			run_d <= run;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 8'h00;
			backlight_drive_o <= 1'b0;
			dim_active_o <= 1'b0;
			ovp_rampdown_o <= 1'b0;
			fade_override_o <= 1'b0;
			fade_transfer_law_o <= BLC_LAW_LINEAR;
			brightness_level_sel_o <= BLC_LVL_DAYLIGHT;
		end else begin
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
			backlight_drive_o <= run;
			dim_active_o <= run && dim_enable;
			ovp_rampdown_o <= run && overvoltage_rampdown_enable && ovp_s2;
			fade_override_o <= standby_release && fade_override_enable;
			fade_transfer_law_o <= fade_transfer_law;
			brightness_level_sel_o <= brightness_level_sel;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_level_manual: assert property (!ambient_auto_level && !wr_ctrl |=>
		brightness_level_sel == $past(brightness_level_sel))
		else $error("level moved without auto mode or write");
	a_level_auto: assert property (ambient_auto_level && amb_s2 != 2'h3 |=>
		brightness_level_sel == $past(amb_s2) ##1 brightness_level_sel_o == $past(amb_s2, 2))
		else $error("level does not follow comparators");
	a_law_out: assert property (wr_ctrl |=> ##1
		fade_transfer_law_o == $past(reg_wdata_i[BLC_LAW_HI:BLC_LAW_LO], 2))
		else $error("fade law not presented");
	a_ovp_gate: assert property (!overvoltage_rampdown_enable |=> !ovp_rampdown_o)
		else $error("ramp-down while disabled");
	a_override_out: assert property (wr_ctrl && standby_release && !wr_mode |=> ##1
		fade_override_o == $past(reg_wdata_i[BLC_OVRD_BIT], 2))
		else $error("fade override mismatch");
	a_key_wake: assert property (key_wake |=>
		backlight_on ##1 backlight_drive_o == $past(standby_release))
		else $error("key press did not wake backlight");
	a_key_ignored: assert property (key_press_i && !keypress_wake_enable &&
		!backlight_on && !wr_mode |=> !backlight_on)
		else $error("key press acted while disabled");
	a_off_decode: assert property (reload && off_timer_code == 4'hF |=> off_cnt == 7'h78)
		else $error("off timer code 15 not 120 s");
	a_dim_decode: assert property (reload && dim_timer_code == 4'h7 |=> dim_cnt == 7'h28)
		else $error("dim timer code 7 not 40 s");
	a_dim_expiry: assert property (dim_exp |=> dim_enable)
		else $error("dim expiry did not set dim");
	a_off_expiry: assert property (off_exp && !key_wake && !wr_mode |=>
		!backlight_on ##1 !backlight_drive_o)
		else $error("off expiry left backlight on");
	a_standby_dark: assert property (!standby_release |=> !backlight_drive_o)
		else $error("backlight driven in standby");
	a_level_write: assert property (!ambient_auto_level && wr_ctrl |=>
		brightness_level_sel == $past(reg_wdata_i[BLC_LVL_HI:BLC_LVL_LO]))
		else $error("level write not taken in manual mode");
	a_auto_write: assert property (ambient_auto_level && wr_ctrl |=>
		brightness_level_sel == $past(amb_lvl))
		else $error("level write overrode auto mode");
	a_level_dark: assert property (ambient_auto_level && amb_s2 == 2'h3 |=>
		brightness_level_sel == BLC_LVL_DARK)
		else $error("unused comparator code not dark");
	a_law_hold: assert property (!wr_ctrl |=>
		fade_transfer_law == $past(fade_transfer_law))
		else $error("fade law moved without write");
	a_ovp_ramp: assert property (run && overvoltage_rampdown_enable && ovp_s2 |=>
		ovp_rampdown_o)
		else $error("no ramp-down during overvoltage");
	a_ovp_hold: assert property (!ovp_s2 |=>
		!ovp_rampdown_o)
		else $error("ramp-down without overvoltage");
	a_override_gate: assert property (!fade_override_enable |=>
		!fade_override_o)
		else $error("fade override while disabled");
	a_drive_run: assert property (run |=>
		backlight_drive_o)
		else $error("backlight not driven while running");
	a_dim_gate: assert property (!run |=>
		!dim_active_o)
		else $error("dim shown while not running");

	// ----------------------------------------
	// timer assertions
	// ----------------------------------------
	a_dim_hold: assert property (dim_enable && !wr_mode |=>
		dim_enable)
		else $error("dim bit dropped without clear");
	a_off_zero: assert property (reload && off_timer_code == BLC_CODE_OFF |=>
		off_cnt == 7'h00)
		else $error("off timer code 0 not disabled");
	a_dim_zero: assert property (reload && dim_timer_code == BLC_CODE_OFF |=>
		dim_cnt == 7'h00)
		else $error("dim timer code 0 not disabled");
	a_off_short: assert property (reload && off_timer_code == 4'h1 |=>
		off_cnt == 7'h0A)
		else $error("off timer code 1 not 10 s");
	a_dim_long: assert property (reload && dim_timer_code == 4'h8 |=>
		dim_cnt == 7'h32)
		else $error("dim timer code 8 not 50 s");
	a_count_frozen: assert property (!run |=>
		off_cnt == $past(off_cnt) && dim_cnt == $past(dim_cnt))
		else $error("timer moved while not running");

	// ----------------------------------------
	// covers
	// ----------------------------------------
	c_key_wake: cover property (key_wake ##1 backlight_drive_o);
	c_ovp_ramp: cover property (ovp_rampdown_o ##1 !ovp_rampdown_o);
	c_dim_expiry: cover property (dim_exp ##1 dim_active_o);
	c_off_expiry: cover property (off_exp ##2 !backlight_drive_o);
	c_auto_level: cover property (ambient_auto_level && $changed(brightness_level_sel));
endmodule : blc_core

// *** testbench/blc_env_model.sv ***
`timescale 1ns/1ps
module blc_env_model
	import blc_pkg::*;
(
	// clock
	input wire logic ref_clk_i,
	// bench requests
	input wire logic [1:0] lvl_req_i,
	input wire logic ovp_req_i,
	input wire logic key_req_i,
	// towards the block
	output logic [1:0] ambient_level_o,
	output logic ovp_detect_o,
	output logic key_press_o
);
	logic key_q;
	initial begin
		ambient_level_o = 2'h0;
		ovp_detect_o = 1'b0;
		key_press_o = 1'b0;
		key_q = 1'b0;
	end
	// comparator and ovp levels, keypad emits one pulse per press
	always @(posedge ref_clk_i) begin
		ambient_level_o <= lvl_req_i;
		ovp_detect_o <= ovp_req_i;
		key_q <= key_req_i;
		key_press_o <= key_req_i & ~key_q;
	end
endmodule : blc_env_model

// *** testbench/blc_core_tb.sv ***
`timescale 1ns/1ps
module blc_core_tb
	import blc_pkg::*;
;
	localparam int CPS = 2;
	logic ref_clk_i, rst_b_i, reg_wr_i, reg_rd_i, ovp_req, key_req, ovp_det, key_p;
	logic drive, dim, ovp_rd, fade_ovr;
	logic [7:0] reg_addr_i, reg_wdata_i, rdata;
	logic [1:0] lvl_req, amb, lvl, law;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	// ----------------------------------------
	// clock, instances, timeout
	// ----------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	blc_env_model blc_env_model_i (.ref_clk_i(ref_clk_i), .lvl_req_i(lvl_req),
		.ovp_req_i(ovp_req), .key_req_i(key_req), .ambient_level_o(amb),
		.ovp_detect_o(ovp_det), .key_press_o(key_p));
	blc_core #(.CYC_PER_SEC(CPS)) blc_core_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .ambient_level_i(amb),
		.ovp_detect_i(ovp_det), .key_press_i(key_p), .brightness_level_sel_o(lvl),
		.fade_transfer_law_o(law), .backlight_drive_o(drive), .dim_active_o(dim),
		.ovp_rampdown_o(ovp_rd), .fade_override_o(fade_ovr));
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			$display("[ERR] %0t timeout", $time);
			error_cnt = error_cnt + 1;
			summarize();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task summarize();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i) begin
			reg_addr_i <= a;
			reg_wdata_i <= d;
			reg_wr_i <= 1'b1;
		end
		@(posedge ref_clk_i) reg_wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk_i) begin
			reg_addr_i <= a;
			reg_rd_i <= 1'b1;
		end
		@(posedge ref_clk_i) reg_rd_i <= 1'b0;
		#1 chk(rdata, exp, "read");
	endtask : rd
	task wt(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : wt
	// outputs packed as ovp, override, dim, drive, level, law
	task outs(input int n, input logic [7:0] exp);
		wt(n);
		chk({ovp_rd, fade_ovr, dim, drive, lvl, law}, exp, "outputs");
	endtask : outs
	task keyp();
		@(posedge ref_clk_i) key_req <= 1'b1;
		@(posedge ref_clk_i) key_req <= 1'b0;
	endtask : keyp
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_b_i = 1'b0;
		{reg_wr_i, reg_rd_i, ovp_req, key_req, lvl_req, reg_addr_i, reg_wdata_i} = '0;
		repeat (3) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(BLC_MODE_ADDR, BLC_MODE_RESET);
		rd(BLC_CTRL_ADDR, BLC_CTRL_RESET);
		rd(BLC_TIME_ADDR, BLC_TIME_RESET);
		wr(8'h01, 8'hFF);
		rd(8'h01, 8'h00);
		$display("test reset done");
		for (int l = 0; l < 3; l++) begin
			for (int w = 0; w < 4; w++) begin
				wr(BLC_CTRL_ADDR, {l[1:0], w[1:0], 4'h0});
				outs(2, {4'h0, l[1:0], w[1:0]});
				rd(BLC_CTRL_ADDR, {l[1:0], w[1:0], 4'h0});
			end
		end
		$display("test level law done");
		@(posedge ref_clk_i) lvl_req <= 2'h3;
		wr(BLC_CTRL_ADDR, 8'h48);
		outs(5, 8'h08);
		@(posedge ref_clk_i) lvl_req <= 2'h1;
		outs(5, 8'h04);
		wr(BLC_CTRL_ADDR, 8'h80);
		outs(4, 8'h04);
		wr(BLC_CTRL_ADDR, 8'h80);
		outs(2, 8'h08);
		@(posedge ref_clk_i) lvl_req <= 2'h0;
		outs(5, 8'h08);
		$display("test auto level done");
		wr(BLC_CTRL_ADDR, 8'h06);
		wr(BLC_MODE_ADDR, 8'hC0);
		@(posedge ref_clk_i) ovp_req <= 1'b1;
		outs(5, 8'hD0);
		wr(BLC_CTRL_ADDR, 8'h02);
		outs(2, 8'h50);
		wr(BLC_CTRL_ADDR, 8'h00);
		outs(2, 8'h10);
		@(posedge ref_clk_i) ovp_req <= 1'b0;
		wr(BLC_MODE_ADDR, 8'h40);
		outs(2, 8'h00);
		$display("test ovp override standby done");
		wr(BLC_MODE_ADDR, 8'h00);
		wr(BLC_CTRL_ADDR, 8'h01);
		wr(BLC_MODE_ADDR, 8'h80);
		keyp();
		outs(3, 8'h10);
		rd(BLC_MODE_ADDR, 8'hC0);
		wr(BLC_CTRL_ADDR, 8'h00);
		wr(BLC_MODE_ADDR, 8'h80);
		keyp();
		outs(3, 8'h00);
		$display("test key wake done");
		wr(BLC_TIME_ADDR, 8'h87);
		wr(BLC_MODE_ADDR, 8'hC0);
		outs(40 * CPS - 4, 8'h10);
		outs(8, 8'h30);
		rd(BLC_MODE_ADDR, 8'hE0);
		outs(10, 8'h30);
		outs(8, 8'h00);
		rd(BLC_MODE_ADDR, 8'hA0);
		wr(BLC_TIME_ADDR, 8'h10);
		wr(BLC_MODE_ADDR, 8'hC0);
		outs(10 * CPS - 4, 8'h10);
		outs(8, 8'h00);
		wr(BLC_TIME_ADDR, 8'hF8);
		wr(BLC_MODE_ADDR, 8'hC0);
		outs(50 * CPS - 4, 8'h10);
		outs(8, 8'h30);
		outs(70 * CPS - 8, 8'h30);
		outs(8, 8'h00);
		wr(BLC_MODE_ADDR, 8'h80);
		outs(2, 8'h00);
		rd(BLC_MODE_ADDR, 8'h80);
		wr(BLC_MODE_ADDR, 8'hE0);
		outs(2, 8'h30);
		$display("test timers done");
		@(posedge ref_clk_i) rst_b_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		outs(2, 8'h00);
		rd(BLC_MODE_ADDR, BLC_MODE_RESET);
		rd(BLC_TIME_ADDR, BLC_TIME_RESET);
		$display("test mid-run reset done");
		summarize();
	end
endmodule : blc_core_tb
